/* File: rtl/ctl_pkg.sv */
`default_nettype none
package ctl_pkg;

    // ----------------------------------------
    // Widths and fields
    // ----------------------------------------
    localparam int CTL_NUM_TIMING = 4;
    localparam int CTL_VAL_W = 7;
    localparam int CTL_REG_W = 8;
    localparam int CTL_ADDR_W = 12;
    localparam int CTL_DATA_W = 32;
    localparam int CTL_RATE_W = 3;
    localparam int CTL_OV_BIT = 7;
    localparam int CTL_AUTO_W = CTL_NUM_TIMING * CTL_VAL_W;

    // ----------------------------------------
    // Register indices, byte address is index times four
    // ----------------------------------------
    localparam logic [7:0] CTL_IDX_PREP = 8'h40;
    localparam logic [7:0] CTL_IDX_ZERO = 8'h41;
    localparam logic [7:0] CTL_IDX_TRAIL = 8'h42;
    localparam logic [7:0] CTL_IDX_POST = 8'h43;
    localparam logic [7:0] CTL_IDX_RATE = 8'h20;

    // ----------------------------------------
    // Lane rate codes
    // ----------------------------------------
    localparam logic [2:0] CTL_RATE_400 = 3'h0;
    localparam logic [2:0] CTL_RATE_800 = 3'h1;
    localparam logic [2:0] CTL_RATE_1200 = 3'h2;
    localparam logic [2:0] CTL_RATE_1500 = 3'h3;
    localparam logic [2:0] CTL_RATE_1600 = 3'h4;
    localparam logic [2:0] CTL_RATE_RST = CTL_RATE_800;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CTL_PREP_RST = 8'h05;
    localparam logic [7:0] CTL_ZERO_RST = 8'h1b;
    localparam logic [7:0] CTL_TRAIL_RST = 8'h0b;
    localparam logic [7:0] CTL_POST_RST = 8'h0a;
    localparam logic [7:0] CTL_RST_VALS [CTL_NUM_TIMING] =
        '{CTL_PREP_RST, CTL_ZERO_RST, CTL_TRAIL_RST, CTL_POST_RST};

    // ----------------------------------------
    // Automatic tables: post, trail, zero, prepare (prepare lowest)
    // ----------------------------------------
    localparam logic [27:0] CTL_AUTO_400 = {7'h07, 7'h06, 7'h0e, 7'h03};
    localparam logic [27:0] CTL_AUTO_800 = {CTL_POST_RST[6:0], CTL_TRAIL_RST[6:0],
        CTL_ZERO_RST[6:0], CTL_PREP_RST[6:0]};
    localparam logic [27:0] CTL_AUTO_1200 = {7'h0d, 7'h10, 7'h28, 7'h07};
    localparam logic [27:0] CTL_AUTO_1500 = {7'h10, 7'h14, 7'h32, 7'h09};
    localparam logic [27:0] CTL_AUTO_1600 = {7'h11, 7'h15, 7'h36, 7'h0a};

    function automatic logic [CTL_ADDR_W-1:0] ctl_addr(input logic [7:0] idx);
        return {2'h0, idx, 2'h0};
    endfunction : ctl_addr

endpackage : ctl_pkg
`default_nettype wire

/* File: rtl/ctl_rate_lookup.sv */
`timescale 1ns/10ps
`default_nettype none
module ctl_rate_lookup (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Rate select and automatic values
    input wire logic [ctl_pkg::CTL_RATE_W-1:0] rate_sel,
    output logic [ctl_pkg::CTL_AUTO_W-1:0] auto_vals
);
    import ctl_pkg::*;

    logic [CTL_AUTO_W-1:0] table_d;
    logic [CTL_AUTO_W-1:0] auto_q;

    // ----------------------------------------
    // Rate table
    // ----------------------------------------
    always_comb begin
        case (rate_sel)
            CTL_RATE_400: table_d = CTL_AUTO_400;
            CTL_RATE_800: table_d = CTL_AUTO_800;
            CTL_RATE_1200: table_d = CTL_AUTO_1200;
            CTL_RATE_1500: table_d = CTL_AUTO_1500;
            CTL_RATE_1600: table_d = CTL_AUTO_1600;
            default: table_d = CTL_AUTO_800;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            auto_q <= CTL_AUTO_800;
        end else begin
            auto_q <= table_d;
        end
    end

    assign auto_vals = auto_q;

endmodule : ctl_rate_lookup
`default_nettype wire

/* File: rtl/ctl_timing_field.sv */
`timescale 1ns/10ps
`default_nettype none
module ctl_timing_field #(
    parameter logic [7:0] RST_VAL = ctl_pkg::CTL_PREP_RST
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Automatic value and write port
    input wire logic [ctl_pkg::CTL_VAL_W-1:0] auto_val,
    input wire logic wr_en,
    input wire logic [ctl_pkg::CTL_REG_W-1:0] wr_data,
    // Field state
    output logic ov,
    output logic [ctl_pkg::CTL_VAL_W-1:0] val,
    output logic [ctl_pkg::CTL_VAL_W-1:0] eff,
    output logic [ctl_pkg::CTL_REG_W-1:0] rd_data
);
    import ctl_pkg::*;

    logic ov_q;
    logic [CTL_VAL_W-1:0] val_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ov_q <= 1'b0;
            val_q <= RST_VAL[CTL_VAL_W-1:0];
        end else if (wr_en) begin
            ov_q <= wr_data[CTL_OV_BIT];
            if (wr_data[CTL_OV_BIT]) begin
                val_q <= wr_data[CTL_VAL_W-1:0];
            end
        end
    end

    // Override selects the written value, else the automatic one
    assign eff = ov_q ? val_q : auto_val;
    assign ov = ov_q;
    assign val = val_q;
    assign rd_data = {ov_q, eff};

endmodule : ctl_timing_field
`default_nettype wire

/* File: rtl/ctl_clock_lane_timing.sv */
// Local design decision: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ctl_clock_lane_timing (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ctl_pkg::CTL_ADDR_W-1:0] paddr,
    input wire logic [ctl_pkg::CTL_DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic pready,
    output logic [ctl_pkg::CTL_DATA_W-1:0] prdata,
    output logic pslverr,
    // Clock-lane timing to the transmitter
    output logic [ctl_pkg::CTL_VAL_W-1:0] tck_prepare,
    output logic [ctl_pkg::CTL_VAL_W-1:0] tck_zero,
    output logic [ctl_pkg::CTL_VAL_W-1:0] tck_trail,
    output logic [ctl_pkg::CTL_VAL_W-1:0] tck_post,
    output logic [ctl_pkg::CTL_RATE_W-1:0] lane_rate
);
    import ctl_pkg::*;

    // ----------------------------------------
    // Declarations
    // ----------------------------------------
    logic setup;
    logic access;
    logic wr_acc;
    logic hit_rate;
    logic mapped;
    logic rate_ok;
    logic [CTL_NUM_TIMING-1:0] hit_timing;
    logic [CTL_NUM_TIMING-1:0] fld_ov;
    logic [CTL_VAL_W-1:0] fld_val [CTL_NUM_TIMING];
    logic [CTL_VAL_W-1:0] fld_eff [CTL_NUM_TIMING];
    logic [CTL_REG_W-1:0] fld_rd [CTL_NUM_TIMING];
    logic [CTL_VAL_W-1:0] auto_v [CTL_NUM_TIMING];
    logic [CTL_VAL_W-1:0] timing_q [CTL_NUM_TIMING];
    logic [CTL_AUTO_W-1:0] auto_all;
    logic [CTL_RATE_W-1:0] rate_q;
    logic [CTL_REG_W-1:0] rd_d;
    logic [CTL_REG_W-1:0] prdata_q;
    logic seen_q;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    assign setup = psel && !penable;
    assign access = psel && penable;
    assign wr_acc = access && pwrite && pstrb[0];
    assign hit_rate = (paddr == ctl_addr(CTL_IDX_RATE));
    assign mapped = hit_rate || (|hit_timing);
    assign rate_ok = (pwdata[CTL_RATE_W-1:0] <= CTL_RATE_1600);

    assign pready = 1'b1;
    assign pslverr = access && !mapped;
    assign prdata = {24'h00_0000, prdata_q};

    // ----------------------------------------
    // Lane rate register
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rate_q <= CTL_RATE_RST;
        end else if (wr_acc && hit_rate && rate_ok) begin
            rate_q <= pwdata[CTL_RATE_W-1:0];
        end
    end

    assign lane_rate = rate_q;

    ctl_rate_lookup u_lookup (
        .pclk(pclk),
        .presetn(presetn),
        .rate_sel(rate_q),
        .auto_vals(auto_all)
    );

    // ----------------------------------------
    // Timing registers
    // ----------------------------------------
    generate
        for (genvar i = 0; i < CTL_NUM_TIMING; i++) begin : g_fld
            assign hit_timing[i] = (paddr == ctl_addr(CTL_IDX_PREP + 8'(i)));
            assign auto_v[i] = auto_all[i*CTL_VAL_W +: CTL_VAL_W];

            ctl_timing_field #(
                .RST_VAL(CTL_RST_VALS[i])
            ) u_fld (
                .pclk(pclk),
                .presetn(presetn),
                .auto_val(auto_v[i]),
                .wr_en(wr_acc && hit_timing[i]),
                .wr_data(pwdata[CTL_REG_W-1:0]),
                .ov(fld_ov[i]),
                .val(fld_val[i]),
                .eff(fld_eff[i]),
                .rd_data(fld_rd[i])
            );

            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    timing_q[i] <= CTL_RST_VALS[i][CTL_VAL_W-1:0];
                end else begin
                    timing_q[i] <= fld_eff[i];
                end
            end
        end
    endgenerate

    assign tck_prepare = timing_q[0];
    assign tck_zero = timing_q[1];
    assign tck_trail = timing_q[2];
    assign tck_post = timing_q[3];

    // ----------------------------------------
    // Read data, captured in the setup cycle
    // ----------------------------------------
    always_comb begin
        rd_d = 8'h00;
        if (hit_rate) begin
            rd_d = {5'h00, rate_q};
        end
        for (int k = 0; k < CTL_NUM_TIMING; k++) begin
            if (hit_timing[k]) begin
                rd_d = fld_rd[k];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= 8'h00;
        end else if (setup && !pwrite) begin
            prdata_q <= rd_d;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_q <= 1'b0;
        end else begin
            seen_q <= 1'b1;
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    prep_override_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[0] && pwdata[CTL_OV_BIT])
        |=> ##1 tck_prepare == $past(pwdata[CTL_VAL_W-1:0], 2))
        else $error("prepare override value not applied");

    prep_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fld_ov[0] |=> tck_prepare == $past(auto_v[0]))
        else $error("prepare not automatic while override clear");

    zero_override_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[1] && pwdata[CTL_OV_BIT])
        |=> ##1 tck_zero == $past(pwdata[CTL_VAL_W-1:0], 2))
        else $error("zero override value not applied");

    zero_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fld_ov[1] |=> tck_zero == $past(auto_v[1]))
        else $error("zero not automatic while override clear");

    trail_override_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[2] && pwdata[CTL_OV_BIT])
        |=> ##1 tck_trail == $past(pwdata[CTL_VAL_W-1:0], 2))
        else $error("trail override value not applied");

    trail_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fld_ov[2] |=> tck_trail == $past(auto_v[2]))
        else $error("trail not automatic while override clear");

    post_override_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[3] && pwdata[CTL_OV_BIT])
        |=> ##1 tck_post == $past(pwdata[CTL_VAL_W-1:0], 2))
        else $error("post override value not applied");

    post_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !fld_ov[3] |=> tck_post == $past(auto_v[3]))
        else $error("post not automatic while override clear");

    read_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_timing[0] && !fld_ov[0])
        |=> prdata[CTL_REG_W-1:0] == {1'b0, $past(auto_v[0])})
        else $error("read with override clear not automatic");

    read_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_timing[1] && !fld_ov[1])
        |=> prdata[CTL_REG_W-1:0] == {1'b0, $past(auto_v[1])})
        else $error("zero read with override clear not automatic");

    read_trail_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_timing[2] && !fld_ov[2])
        |=> prdata[CTL_REG_W-1:0] == {1'b0, $past(auto_v[2])})
        else $error("trail read with override clear not automatic");

    read_post_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && hit_timing[3] && !fld_ov[3])
        |=> prdata[CTL_REG_W-1:0] == {1'b0, $past(auto_v[3])})
        else $error("post read with override clear not automatic");

    write_back_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[1] && pwdata[CTL_OV_BIT])
        |=> fld_rd[1] == $past(pwdata[CTL_REG_W-1:0]))
        else $error("override write not read back");

    prep_readback_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[0] && pwdata[CTL_OV_BIT])
        |=> fld_rd[0] == $past(pwdata[CTL_REG_W-1:0]))
        else $error("prepare override write not read back");

    trail_readback_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[2] && pwdata[CTL_OV_BIT])
        |=> fld_rd[2] == $past(pwdata[CTL_REG_W-1:0]))
        else $error("trail override write not read back");

    post_readback_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[3] && pwdata[CTL_OV_BIT])
        |=> fld_rd[3] == $past(pwdata[CTL_REG_W-1:0]))
        else $error("post override write not read back");

    rate_table_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (rate_q == CTL_RATE_800) |=> auto_all == CTL_AUTO_800)
        else $error("automatic values do not match 800 rate");

    rate_change_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_rate && pwdata[CTL_RATE_W-1:0] == CTL_RATE_400)
        |=> ##1 auto_all == CTL_AUTO_400)
        else $error("automatic values not updated on rate change");

    prep_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> fld_rd[0] == CTL_PREP_RST)
        else $error("prepare register reset value wrong");

    zero_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> fld_rd[1] == CTL_ZERO_RST)
        else $error("zero register reset value wrong");

    trail_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> fld_rd[2] == CTL_TRAIL_RST)
        else $error("trail register reset value wrong");

    post_reset_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        !seen_q |-> fld_rd[3] == CTL_POST_RST)
        else $error("post register reset value wrong");

    keep_auto_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[2] && !pwdata[CTL_OV_BIT])
        |=> !fld_ov[2] && fld_val[2] == $past(fld_val[2]))
        else $error("plain write disturbed automatic field");

    keep_prep_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[0] && !pwdata[CTL_OV_BIT])
        |=> !fld_ov[0] && fld_val[0] == $past(fld_val[0]))
        else $error("plain write disturbed prepare field");

    keep_zero_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[1] && !pwdata[CTL_OV_BIT])
        |=> !fld_ov[1] && fld_val[1] == $past(fld_val[1]))
        else $error("plain write disturbed zero field");

    keep_post_a: assert property (
        @(posedge pclk) disable iff (!presetn)
        (wr_acc && hit_timing[3] && !pwdata[CTL_OV_BIT])
        |=> !fld_ov[3] && fld_val[3] == $past(fld_val[3]))
        else $error("plain write disturbed post field");

endmodule : ctl_clock_lane_timing
`default_nettype wire

/* File: testbench/ctl_rx_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ctl_rx_model (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Clock-lane timing from the transmitter
    input wire logic [ctl_pkg::CTL_VAL_W-1:0] tck_prepare,
    input wire logic [ctl_pkg::CTL_VAL_W-1:0] tck_zero,
    input wire logic [ctl_pkg::CTL_VAL_W-1:0] tck_trail,
    input wire logic [ctl_pkg::CTL_VAL_W-1:0] tck_post,
    input wire logic [ctl_pkg::CTL_RATE_W-1:0] lane_rate,
    // Timing as latched by the receiver
    output logic [ctl_pkg::CTL_AUTO_W-1:0] seen_timing,
    output logic [ctl_pkg::CTL_RATE_W-1:0] seen_rate
);
    import ctl_pkg::*;

    // ----------------------------------------
    // Receiver latches its timing set each clock
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            seen_timing <= '0;
            seen_rate <= '0;
        end else begin
            seen_timing <= {tck_post, tck_trail, tck_zero, tck_prepare};
            seen_rate <= lane_rate;
        end
    end
endmodule : ctl_rx_model
`default_nettype wire

/* File: testbench/ctl_clock_lane_timing_tb_top.sv */
`timescale 1ns/10ps
`default_nettype none
module ctl_clock_lane_timing_tb_top;
    import ctl_pkg::*;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [CTL_ADDR_W-1:0] paddr;
    logic [CTL_DATA_W-1:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic [CTL_VAL_W-1:0] tck_prepare, tck_zero, tck_trail, tck_post, v;
    logic [CTL_RATE_W-1:0] lane_rate, seen_rate;
    logic [CTL_AUTO_W-1:0] seen_timing;
    logic [27:0] auto_tab [5];
    logic [7:0] rst_vals [4] = '{8'h05, 8'h1b, 8'h0b, 8'h0a};
    logic m_ov [4];
    logic [6:0] m_val [4];
    int m_rate, errors, comparisons, i, r;

    ctl_clock_lane_timing u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .pready(pready), .prdata(prdata), .pslverr(pslverr),
        .tck_prepare(tck_prepare), .tck_zero(tck_zero), .tck_trail(tck_trail),
        .tck_post(tck_post), .lane_rate(lane_rate));
    ctl_rx_model u_rx (.pclk(pclk), .presetn(presetn), .tck_prepare(tck_prepare),
        .tck_zero(tck_zero), .tck_trail(tck_trail), .tck_post(tck_post),
        .lane_rate(lane_rate), .seen_timing(seen_timing), .seen_rate(seen_rate));

    // ----------------------------------------
    // Clock and watchdog
    // ----------------------------------------
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    initial begin
        #800000;
        errors++;
        complete_run();
    end

    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, comparisons);
        if (errors == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_read(input string what, input logic [7:0] exp, input logic [31:0] got);
        chk(what, {24'h00_0000, exp}, got);
    endtask : chk_read
    task automatic chk_err(input string what, input logic exp, input logic got);
        chk(what, {31'h0, exp}, {31'h0, got});
    endtask : chk_err
    task automatic chk_rx(input string what, input logic [6:0] exp, input logic [6:0] got);
        chk(what, {25'h0, exp}, {25'h0, got});
    endtask : chk_rx
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) errors++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    function automatic logic [7:0] exp_reg(input int k);
        return m_ov[k] ? {1'b1, m_val[k]} : {1'b0, auto_tab[m_rate][k*7 +: 7]};
    endfunction : exp_reg
    task automatic wr(input int k, input logic [7:0] d);
        apb(1'b1, 12'h100 + 12'(k * 4), {24'h00_0000, d});
        m_ov[k] = d[7];
        if (d[7]) m_val[k] = d[6:0];
    endtask : wr
    task automatic wr_rate(input int k);
        apb(1'b1, 12'h080, 32'(k));
        if (k <= 4) m_rate = k;
    endtask : wr_rate
    task automatic check_all();
        logic [7:0] e;
        logic [6:0] t;
        for (int k = 0; k < 4; k++) begin
            apb(1'b0, 12'h100 + 12'(k * 4), 32'h0000_0000);
            e = exp_reg(k);
            chk_read("register read", e, rd);
            chk_err("register slverr", 1'b0, err);
            @(negedge pclk);
            t = seen_timing[k*7 +: 7];
            chk_rx("timing output", e[6:0], t);
        end
        chk_rx("lane rate", 7'(m_rate), 7'(seen_rate));
    endtask : check_all

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        errors = 0;
        comparisons = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = 4'hf;
        void'($urandom(32'hb8f2_64c7));
        auto_tab = '{CTL_AUTO_400, CTL_AUTO_800, CTL_AUTO_1200, CTL_AUTO_1500, CTL_AUTO_1600};
        m_rate = 1;
        for (i = 0; i < 4; i++) m_ov[i] = 1'b0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        for (i = 0; i < 4; i++) begin
            apb(1'b0, 12'h100 + 12'(i * 4), 32'h0000_0000);
            chk_read("reset value", rst_vals[i], rd);
        end
        for (i = 0; i < 4; i++) begin
            v = 7'($urandom());
            wr(i, {1'b0, v});
        end
        check_all();
        for (i = 0; i < 4; i++) begin
            v = 7'($urandom());
            wr(i, {1'b1, v});
        end
        check_all();
        wr(1, 8'h00);
        wr(3, {1'b0, 7'($urandom())});
        check_all();
        for (r = 0; r < 5; r++) begin
            wr_rate(r);
            check_all();
        end
        wr(0, 8'h00);
        wr(2, 8'h7f);
        wr_rate(1);
        check_all();
        apb(1'b1, 12'h0fc, 32'h0000_00ff);
        chk_err("unmapped slverr", 1'b1, err);
        apb(1'b0, 12'h0fc, 32'h0000_0000);
        chk_read("unmapped read", 8'h00, rd);
        pstrb <= 4'he;
        apb(1'b1, 12'h100, 32'h0000_00ff);
        pstrb <= 4'hf;
        wr_rate(5 + int'($urandom_range(2)));
        check_all();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        m_rate = 1;
        for (i = 0; i < 4; i++) m_ov[i] = 1'b0;
        check_all();
        complete_run();
    end
endmodule : ctl_clock_lane_timing_tb_top
`default_nettype wire
